// ==== verilog/framer_timing_ctrl.sv ====
// Eight-framer configuration, reset and transmit timing control
// Assumes an AXI4-Lite master on sys_clk and a synchronous reset pin input
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`include "framer_timing_map.svh"
`timescale 1ns/1ps
`default_nettype none

module framer_timing_ctrl #(
  parameter int FRAMERS = 8,
  parameter int SLOTS = 10
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Hardware reset pin, synchronous to sys_clk
  input wire logic hw_reset_n,
  // AXI4-Lite write address and data
  input wire logic [12:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [12:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Per-framer control toward the path blocks
  output framer_timing_pkg::framer_ctrl_t framer_ctrl [FRAMERS],
  // Device-wide status
  output logic device_j_mode,
  output logic device_e1_mode,
  output logic device_reset_active,
  output logic xtal_div24_clk
);
  import framer_timing_pkg::*;
  localparam int RST_MIN_CYC = (`HW_RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int HALF_DIV = `XTAL_DIVIDE / 2;
  typedef enum logic {WR_IDLE, WR_RESP} wr_state_t;
  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  // Slot of a per-framer register, SLOTS when none
  function automatic logic [3:0] slot_of(input logic [6:0] ofs);
    if (ofs == `FPC_OFS) begin
      slot_of = 4'h0;
    end else if (ofs == `DIV_ONE_OFS) begin
      slot_of = 4'h1;
    end else if (ofs == `DIV_TWO_OFS) begin
      slot_of = 4'h2;
    end else if (ofs == `ALARM_DETECTOR_OFS) begin
      slot_of = 4'h3;
    end else if (ofs == `FGC_OFS) begin
      slot_of = 4'h4;
    end else if (ofs == `TIMING_OFS) begin
      slot_of = 4'h5;
    end else if (ofs == `BLOCK_EN_OFS) begin
      slot_of = 4'h6;
    end else if (ofs == `PATH_CFG_OFS) begin
      slot_of = 4'h7;
    end else if (ofs == `RX_DIV_ONE_OFS) begin
      slot_of = 4'h8;
    end else if (ofs == `RX_DIV_TWO_OFS) begin
      slot_of = 4'h9;
    end else begin
      slot_of = 4'(SLOTS);
    end
  endfunction
  function automatic logic [7:0] slot_reset(input int s);
    if (s == 1 || s == 2 || s == 8 || s == 9) begin
      slot_reset = `DIVISOR_RST;
    end else if (s == 5) begin
      slot_reset = `TIMING_RST;
    end else begin
      slot_reset = `ZERO_RST;
    end
  endfunction
  // Reset bit location follows the line standard
  function automatic logic is_reset_ofs(input logic [6:0] ofs, input logic e1);
    is_reset_ofs = e1 ? (ofs == `RESET_OFS_E1) : (ofs == `RESET_OFS_T1);
  endfunction
  // ---------------------------------------------------------------
  // Hardware reset pin qualification
  // ---------------------------------------------------------------
  logic [7:0] pin_low_cnt_reg;
  logic dev_rst_reg;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_low_cnt_reg <= 8'h00;
      dev_rst_reg <= 1'b0;
    end else if (hw_reset_n) begin
      pin_low_cnt_reg <= 8'h00;
      dev_rst_reg <= 1'b0;
    end else if (pin_low_cnt_reg < 8'(RST_MIN_CYC - 1)) begin
      pin_low_cnt_reg <= pin_low_cnt_reg + 8'h01;
    end else begin
      dev_rst_reg <= 1'b1;
    end
  end
  // ---------------------------------------------------------------
  // AXI write channel
  // ---------------------------------------------------------------
  wr_state_t wr_state_reg;
  logic [12:0] aw_addr_reg;
  logic aw_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_held_reg;
  logic wr_go;
  logic [`IDX_W-1:0] wr_idx;
  logic [3:0] wr_slot;
  logic [2:0] wr_fr;
  logic wr_global;
  logic wr_ok;
  assign wr_go = (wr_state_reg == WR_IDLE) && aw_held_reg && w_held_reg;
  assign wr_idx = aw_addr_reg[12:2];
  assign wr_fr = wr_idx[`IDX_FRAMER_HI:`IDX_FRAMER_LO];
  assign wr_global = wr_idx[`IDX_GLOBAL_BIT];
  assign wr_slot = slot_of(wr_idx[`IDX_OFS_HI:0]);
  assign wr_ok = wr_global ? (wr_idx == `STANDARD_SELECT_IDX || wr_idx == `E1_SELECT_IDX)
               : (wr_slot != 4'(SLOTS) || is_reset_ofs(wr_idx[`IDX_OFS_HI:0], device_e1_mode));
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 13'h0000;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_go) begin
      aw_held_reg <= 1'b0;
    end else if (wr_state_reg == WR_RESP && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_go) begin
      w_held_reg <= 1'b0;
    end else if (wr_state_reg == WR_RESP && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_state_reg <= WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      case (wr_state_reg)
        WR_IDLE: begin
          if (wr_go) begin
            wr_state_reg <= WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_reg <= WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state_reg <= WR_IDLE;
        end
      endcase
    end
  end
  // ---------------------------------------------------------------
  // Global registers
  // ---------------------------------------------------------------
  logic std_j_reg;
  logic std_e1_reg;
  logic byte0_wr;
  assign byte0_wr = wr_go && wr_ok && w_strb_reg[0];
  // Framer resets leave these untouched
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      std_j_reg <= 1'b0;
      std_e1_reg <= 1'b0;
    end else if (dev_rst_reg) begin
      std_j_reg <= 1'b0;
      std_e1_reg <= 1'b0;
    end else if (byte0_wr && wr_idx == `STANDARD_SELECT_IDX) begin
      std_j_reg <= w_data_reg[`STD_J_BIT];
    end else if (byte0_wr && wr_idx == `E1_SELECT_IDX) begin
      std_e1_reg <= w_data_reg[`STD_J_BIT];
    end
  end
  // ---------------------------------------------------------------
  // Per-framer register copies
  // ---------------------------------------------------------------
  logic [7:0] regs_reg [FRAMERS][SLOTS];
  logic [FRAMERS-1:0] fr_rst_reg;
  for (genvar f = 0; f < FRAMERS; f++) begin : g_framer
    logic sel;
    assign sel = byte0_wr && !wr_global && wr_fr == 3'(f);

    // Reset request seen one cycle after the write
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        fr_rst_reg[f] <= 1'b0;
      end else begin
        fr_rst_reg[f] <= sel && w_data_reg[`RESET_BIT]
                         && is_reset_ofs(wr_idx[`IDX_OFS_HI:0], std_e1_reg);
      end
    end

    for (genvar s = 0; s < SLOTS; s++) begin : g_slot
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          regs_reg[f][s] <= slot_reset(s);
        end else if (dev_rst_reg || fr_rst_reg[f]) begin
          regs_reg[f][s] <= slot_reset(s);
        end else if (sel && wr_slot == 4'(s)) begin
          regs_reg[f][s] <= w_data_reg[7:0];
        end
      end
    end

    // Transmit timing decode
    tx_mode_t mode;
    logic rate_hi;
    logic alt;
    ref_sel_t dpll_ref;
    line_src_t line_src;
    assign mode = tx_mode_t'(regs_reg[f][5][`TIM_MODE_HI:`TIM_MODE_LO]);
    assign rate_hi = regs_reg[f][5][`TIM_RATE_BIT];
    assign alt = regs_reg[f][5][`TIM_ALT_BIT];
    always_comb begin
      dpll_ref = REF_SYS_A;
      line_src = LINE_SMOOTHED;
      case (mode)
        TX_SLAVE: begin
          if (!rate_hi && alt) begin
            dpll_ref = REF_SYS_B;
          end else begin
            dpll_ref = REF_SYS_A;
          end
        end
        TX_MASTER: begin
          dpll_ref = REF_XTAL_DIV24;
          line_src = LINE_XTAL_DIV24;
        end
        TX_MUX: begin
          if (rate_hi && alt) begin
            dpll_ref = REF_SYS_A_DIV8;
          end else begin
            dpll_ref = REF_SYS_A;
          end
        end
        default: begin
          dpll_ref = REF_SYS_A;
        end
      endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        framer_ctrl[f] <= '{dpll_ref: REF_SYS_B, line_tx_clock_src: LINE_SMOOTHED,
                            divisor_one: `DIVISOR_RST, divisor_two: `DIVISOR_RST,
                            rx_divisor_one: `DIVISOR_RST, rx_divisor_two: `DIVISOR_RST,
                            path_cfg: `ZERO_RST, block_en: `ZERO_RST,
                            framer_reset: 1'b1, default: 1'b0};
      end else begin
        framer_ctrl[f].dpll_ref <= dpll_ref;
        framer_ctrl[f].line_tx_clock_src <= line_src;
        framer_ctrl[f].divisor_one <= regs_reg[f][1];
        framer_ctrl[f].divisor_two <= regs_reg[f][2];
        framer_ctrl[f].rx_divisor_one <= regs_reg[f][8];
        framer_ctrl[f].rx_divisor_two <= regs_reg[f][9];
        framer_ctrl[f].rx_esf <= regs_reg[f][0][`FPC_ESF_BIT];
        framer_ctrl[f].alarm_esf <= regs_reg[f][3][`ALARM_DETECTOR_ESF_BIT];
        framer_ctrl[f].tx_esf <= regs_reg[f][4][`FGC_ESF_BIT];
        framer_ctrl[f].rx_j_framing_sel <= regs_reg[f][0][`FPC_J_BIT];
        framer_ctrl[f].alarm_j_sel <= regs_reg[f][3][`ALARM_DETECTOR_J_BIT];
        framer_ctrl[f].j_crc_framing_sel <= regs_reg[f][4][`FGC_J_CRC_BIT];
        framer_ctrl[f].j_yellow_sel <= regs_reg[f][4][`FGC_J_YEL_BIT];
        framer_ctrl[f].path_cfg <= regs_reg[f][7];
        framer_ctrl[f].block_en <= regs_reg[f][6];
        framer_ctrl[f].framer_reset <= dev_rst_reg || fr_rst_reg[f];
      end
    end
  end
  // ---------------------------------------------------------------
  // AXI read channel
  // ---------------------------------------------------------------
  logic [`IDX_W-1:0] rd_idx;
  logic [3:0] rd_slot;
  logic [2:0] rd_fr;
  assign rd_idx = s_axi_araddr[12:2];
  assign rd_slot = slot_of(rd_idx[`IDX_OFS_HI:0]);
  assign rd_fr = rd_idx[`IDX_FRAMER_HI:`IDX_FRAMER_LO];
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
      if (rd_idx == `STANDARD_SELECT_IDX) begin
        s_axi_rdata <= {31'h0, std_j_reg};
      end else if (rd_idx == `E1_SELECT_IDX) begin
        s_axi_rdata <= {31'h0, std_e1_reg};
      end else if (!rd_idx[`IDX_GLOBAL_BIT] && rd_slot != 4'(SLOTS)) begin
        s_axi_rdata <= {24'h0, regs_reg[rd_fr][rd_slot]};
      end else if (!rd_idx[`IDX_GLOBAL_BIT]
                   && is_reset_ofs(rd_idx[`IDX_OFS_HI:0], std_e1_reg)) begin
        s_axi_rdata <= 32'h0000_0000;
      end else begin
        s_axi_rresp <= 2'h2;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
  // ---------------------------------------------------------------
  // Crystal clock divider and status
  // ---------------------------------------------------------------
  logic [4:0] div_cnt_reg;
  // sys_clk stands in for the master crystal clock
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_cnt_reg <= 5'h00;
      xtal_div24_clk <= 1'b0;
    end else if (div_cnt_reg == 5'(HALF_DIV - 1)) begin
      div_cnt_reg <= 5'h00;
      xtal_div24_clk <= !xtal_div24_clk;
    end else begin
      div_cnt_reg <= div_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      device_j_mode <= 1'b0;
      device_e1_mode <= 1'b0;
      device_reset_active <= 1'b1;
    end else begin
      device_j_mode <= std_j_reg;
      device_e1_mode <= std_e1_reg;
      device_reset_active <= dev_rst_reg;
    end
  end

endmodule // framer_timing_ctrl

`default_nettype wire

// ==== inc/framer_timing_map.svh ====
// Register indices, field positions, reset values and timing constants
// Assumes index addressing: byte address is four times the register index
`ifndef FRAMER_TIMING_MAP_SVH
`define FRAMER_TIMING_MAP_SVH

// Address layout (indices)
`define IDX_W 11
`define IDX_GLOBAL_BIT 10
`define IDX_FRAMER_HI 9
`define IDX_FRAMER_LO 7
`define IDX_OFS_HI 6
`define STANDARD_SELECT_IDX 11'h400
`define E1_SELECT_IDX 11'h401

// Per-framer register offsets within one 80H framer window
`define RESET_OFS_E1 7'h0a
`define RESET_OFS_T1 7'h0d
`define FPC_OFS 7'h20
`define DIV_ONE_OFS 7'h25
`define DIV_TWO_OFS 7'h26
`define ALARM_DETECTOR_OFS 7'h2c
`define FGC_OFS 7'h44
`define RX_DIV_ONE_OFS 7'h7a
`define RX_DIV_TWO_OFS 7'h7b
`define PATH_CFG_OFS 7'h7c
`define BLOCK_EN_OFS 7'h7d
`define TIMING_OFS 7'h7e

// Reset values
`define DIVISOR_RST 8'h2f
`define TIMING_RST 8'h10
`define ZERO_RST 8'h00

// Field positions
`define RESET_BIT 0
`define STD_J_BIT 0
`define FPC_J_BIT 3
`define FPC_ESF_BIT 4
`define ALARM_DETECTOR_J_BIT 5
`define ALARM_DETECTOR_ESF_BIT 4
`define FGC_ESF_BIT 4
`define FGC_J_YEL_BIT 5
`define FGC_J_CRC_BIT 6
`define TIM_MODE_HI 1
`define TIM_MODE_LO 0
`define TIM_RATE_BIT 2
`define TIM_ALT_BIT 4

// Timing
`define CLK_PERIOD_NS 10
`define HW_RESET_MIN_NS 100
`define XTAL_DIVIDE 24

`endif

// ==== inc/framer_timing_pkg.sv ====
// Types shared by the framer timing and defaults block
// Assumes nothing beyond a SystemVerilog compiler
package framer_timing_pkg;

  typedef enum logic [1:0] {REF_SYS_A, REF_SYS_B, REF_SYS_A_DIV8, REF_XTAL_DIV24} ref_sel_t;
  typedef enum logic {LINE_SMOOTHED, LINE_XTAL_DIV24} line_src_t;
  typedef enum logic [1:0] {TX_SLAVE, TX_MASTER, TX_MUX, TX_RSVD} tx_mode_t;

  typedef struct packed {
    ref_sel_t dpll_ref;
    line_src_t line_tx_clock_src;
    logic [7:0] divisor_one;
    logic [7:0] divisor_two;
    logic [7:0] rx_divisor_one;
    logic [7:0] rx_divisor_two;
    logic rx_esf;
    logic tx_esf;
    logic alarm_esf;
    logic rx_j_framing_sel;
    logic alarm_j_sel;
    logic j_crc_framing_sel;
    logic j_yellow_sel;
    logic [7:0] path_cfg;
    logic [7:0] block_en;
    logic framer_reset;
  } framer_ctrl_t;

endpackage

// ==== bench/reset_pin_source.sv ====
// Board-side source for the device reset pin
// Assumes the bench requests each low pulse with its length in cycles
`timescale 1ns/1ps
`default_nettype none
module reset_pin_source (
  // Clock
  input wire logic sys_clk,
  // Pulse request
  input wire logic pulse_start,
  input wire logic [4:0] pulse_len,
  // Reset pin, active low
  output logic hw_reset_n
);
  logic [4:0] low_left = 5'h0;
  // Holds the pin low for exactly the requested number of cycles
  always @(posedge sys_clk) begin
    if (pulse_start) begin
      low_left <= pulse_len;
    end else if (low_left != 5'h0) begin
      low_left <= low_left - 5'h1;
    end
  end
  assign hw_reset_n = (low_left == 5'h0);
endmodule // reset_pin_source
`default_nettype wire

// ==== bench/framer_timing_properties.sv ====
// Port-level checks for the framer timing block
// Assumes a bind into framer_timing_ctrl and one clock domain
`timescale 1ns/1ps
`default_nettype none
module framer_timing_properties #(
  parameter int FRAMERS = 8
) (
  // Clock and resets
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hw_reset_n,
  // Register bus read side
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Control outputs
  input wire framer_timing_pkg::framer_ctrl_t framer_ctrl [FRAMERS],
  input wire logic device_j_mode,
  input wire logic device_reset_active,
  input wire logic xtal_div24_clk
);
  import framer_timing_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [3:0] low_cnt;
  logic [3:0] tick_cnt;
  logic tick_seen;
  logic xtal_last;
  // Consecutive low samples of the reset pin
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      low_cnt <= 4'h0;
    end else if (hw_reset_n) begin
      low_cnt <= 4'h0;
    end else if (low_cnt != 4'hf) begin
      low_cnt <= low_cnt + 4'h1;
    end
  end
  // Cycles since the divided crystal clock last toggled
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_cnt <= 4'h0;
      tick_seen <= 1'b0;
      xtal_last <= 1'b0;
    end else begin
      xtal_last <= xtal_div24_clk;
      if (device_reset_active) begin
        tick_cnt <= 4'h0;
        tick_seen <= 1'b0;
      end else if (xtal_div24_clk != xtal_last) begin
        tick_cnt <= 4'h0;
        tick_seen <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 4'h1;
      end
    end
  end
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");
  property p_read_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  a_read_done: assert property (p_read_done) else $error("read not closed");
  property p_xtal_period;
    tick_seen && $changed(xtal_div24_clk) |-> tick_cnt == 4'd11;
  endproperty
  a_xtal_period: assert property (p_xtal_period) else $error("crystal divide wrong");
  property p_xtal_pair;
    (framer_ctrl[0].dpll_ref == REF_XTAL_DIV24)
      == (framer_ctrl[0].line_tx_clock_src == LINE_XTAL_DIV24);
  endproperty
  a_xtal_pair: assert property (p_xtal_pair) else $error("line clock source split");
  property p_pin_qualify;
    $rose(device_reset_active) |-> $past(low_cnt) >= 4'd10;
  endproperty
  a_pin_qualify: assert property (p_pin_qualify) else $error("short pin pulse taken");
  property p_pin_defaults;
    device_reset_active |-> ##2 framer_ctrl[0].divisor_one == 8'h2f
      && framer_ctrl[0].divisor_two == 8'h2f && framer_ctrl[0].rx_divisor_one == 8'h2f
      && framer_ctrl[0].dpll_ref == REF_SYS_B && framer_ctrl[0].path_cfg == 8'h00
      && framer_ctrl[0].block_en == 8'h00 && !framer_ctrl[0].rx_esf && !framer_ctrl[0].tx_esf;
  endproperty
  a_pin_defaults: assert property (p_pin_defaults) else $error("defaults lost");
  property p_pin_mode;
    device_reset_active |-> ##2 !device_j_mode;
  endproperty
  a_pin_mode: assert property (p_pin_mode) else $error("standard not T1");
  property p_framer_clear;
    framer_ctrl[0].framer_reset |-> ##2 framer_ctrl[0].divisor_one == 8'h2f
      && !framer_ctrl[0].rx_j_framing_sel && !framer_ctrl[0].j_crc_framing_sel;
  endproperty
  a_framer_clear: assert property (p_framer_clear) else $error("framer not cleared");
  c_pin_reset: cover property ($rose(device_reset_active));
  c_framer_reset: cover property (framer_ctrl[0].framer_reset && !device_reset_active);
  c_master_ref: cover property (framer_ctrl[0].dpll_ref == REF_XTAL_DIV24);
endmodule // framer_timing_properties
bind framer_timing_ctrl framer_timing_properties #(.FRAMERS(FRAMERS)) props (
  .sys_clk, .rst, .hw_reset_n, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .framer_ctrl, .device_j_mode, .device_reset_active, .xtal_div24_clk
);
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench for the framer timing block
// Assumes the design package, map header and reset pin source model
`timescale 1ns/1ps
`default_nettype none
`include "framer_timing_map.svh"
module tb_top;
  import framer_timing_pkg::*;
  localparam int FR = 8;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic pulse_start = 1'b0;
  logic [4:0] pulse_len = 5'h0;
  logic hw_reset_n;
  logic [12:0] s_axi_awaddr = 13'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [12:0] s_axi_araddr = 13'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  framer_ctrl_t framer_ctrl [FR];
  logic device_j_mode;
  logic device_e1_mode;
  logic device_reset_active;
  logic xtal_div24_clk;
  int mismatches = 0;
  int compares = 0;
  int seed = 26759;
  logic [7:0] v [FR];
  logic xt;
  logic [6:0] dflt_ofs [11] = '{7'h20, 7'h25, 7'h26, 7'h2c, 7'h44, 7'h7a, 7'h7b,
    7'h7c, 7'h7d, 7'h7e, 7'h0d};
  logic [7:0] dflt_val [11] = '{8'h00, 8'h2f, 8'h2f, 8'h00, 8'h00, 8'h2f, 8'h2f,
    8'h00, 8'h00, 8'h10, 8'h00};
  logic [7:0] modes [9] = '{8'h10, 8'h00, 8'h04, 8'h14, 8'h01, 8'h02, 8'h12, 8'h06, 8'h16};
  always #5 sys_clk = ~sys_clk;
  reset_pin_source pin (.sys_clk, .pulse_start, .pulse_len, .hw_reset_n);
  framer_timing_ctrl #(.FRAMERS(FR)) dut (
    .sys_clk, .rst, .hw_reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .framer_ctrl, .device_j_mode, .device_e1_mode, .device_reset_active,
    .xtal_div24_clk
  );
  // --------------------------------------------------------------
  // Expectations and bus tasks
  // --------------------------------------------------------------
  task automatic stop_test();
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [10:0] fidx(input logic [2:0] f, input logic [6:0] ofs);
    return {1'b0, f, ofs};
  endfunction
  function automatic framer_ctrl_t dflt_ctrl();
    framer_ctrl_t e;
    e = '0;
    e.dpll_ref = REF_SYS_B;
    e.divisor_one = 8'h2f;
    e.divisor_two = 8'h2f;
    e.rx_divisor_one = 8'h2f;
    e.rx_divisor_two = 8'h2f;
    return e;
  endfunction
  function automatic framer_ctrl_t exp_cfg(input logic [7:0] c);
    framer_ctrl_t e;
    e = dflt_ctrl();
    e.divisor_one = c;
    e.rx_esf = c[4];
    e.tx_esf = c[4];
    e.alarm_esf = c[4];
    e.rx_j_framing_sel = c[3];
    e.alarm_j_sel = c[5];
    e.j_yellow_sel = c[5];
    e.j_crc_framing_sel = c[6];
    return e;
  endfunction
  function automatic ref_sel_t exp_ref(input logic [7:0] t);
    case (t[1:0])
      2'd1: return REF_XTAL_DIV24;
      2'd2: return (t[2] && t[4]) ? REF_SYS_A_DIV8 : REF_SYS_A;
      default: return (!t[2] && t[4]) ? REF_SYS_B : REF_SYS_A;
    endcase
  endfunction
  task automatic settle();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  task automatic axi_wr(input logic [10:0] idx, input logic [7:0] val, input logic [1:0] er);
    int n;
    bit done;
    @(posedge sys_clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, val};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    done = 0;
    while (!done && n < 50) begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        done = 1;
        s_axi_bready <= 1'b0;
        chk("bresp", er, s_axi_bresp);
      end
    end
    if (!done) begin
      chk("write answer", 64'h1, 64'h0);
      stop_test();
    end
  endtask
  task automatic rd_chk(input logic [10:0] idx, input logic [7:0] exp, input logic [1:0] er);
    int n;
    bit done;
    @(posedge sys_clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    done = 0;
    while (!done && n < 50) begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        done = 1;
        s_axi_rready <= 1'b0;
        chk("rdata", {24'h0, exp}, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
      end
    end
    if (!done) begin
      chk("read answer", 64'h1, 64'h0);
      stop_test();
    end
  endtask
  task automatic pin_pulse(input logic [4:0] len);
    @(posedge sys_clk);
    pulse_len <= len;
    pulse_start <= 1'b1;
    @(posedge sys_clk);
    pulse_start <= 1'b0;
    repeat (20) @(posedge sys_clk);
    settle();
  endtask
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    for (int f = 0; f < FR; f++) begin
      for (int k = 0; k < 11; k++) begin
        rd_chk(fidx(3'(f), dflt_ofs[k]), dflt_val[k], 2'b00);
      end
      chk("ctrl", dflt_ctrl(), framer_ctrl[f]);
    end
    rd_chk(`STANDARD_SELECT_IDX, 8'h00, 2'b00);
    chk("j_mode", 1'b0, device_j_mode);
    for (int k = 0; k < 3; k++) begin
      xt = xtal_div24_clk;
      repeat (12) @(posedge sys_clk);
      chk("xtal_div24_clk", !xt, xtal_div24_clk);
    end
    for (int f = 0; f < FR; f++) begin
      v[f] = (f == 0) ? 8'hff : (f == 1) ? 8'h00 : 8'($random(seed));
      axi_wr(fidx(3'(f), `FPC_OFS), v[f], 2'b00);
      axi_wr(fidx(3'(f), `ALARM_DETECTOR_OFS), v[f], 2'b00);
      axi_wr(fidx(3'(f), `FGC_OFS), v[f], 2'b00);
      axi_wr(fidx(3'(f), `DIV_ONE_OFS), v[f], 2'b00);
    end
    axi_wr(fidx(3'd1, 7'h30), 8'h55, 2'b10);
    rd_chk(fidx(3'd1, 7'h30), 8'h00, 2'b10);
    settle();
    for (int f = 0; f < FR; f++) begin
      rd_chk(fidx(3'(f), `FGC_OFS), v[f], 2'b00);
      chk("ctrl", exp_cfg(v[f]), framer_ctrl[f]);
    end
    for (int k = 0; k < 9; k++) begin
      axi_wr(fidx(3'd0, `TIMING_OFS), modes[k], 2'b00);
      settle();
      chk("dpll_ref", exp_ref(modes[k]), framer_ctrl[0].dpll_ref);
      chk("line_src", modes[k][1:0] == 2'd1, framer_ctrl[0].line_tx_clock_src);
    end
    axi_wr(`STANDARD_SELECT_IDX, 8'h01, 2'b00);
    settle();
    chk("j_mode", 1'b1, device_j_mode);
    axi_wr(fidx(3'd0, `RESET_OFS_T1), 8'h01, 2'b00);
    settle();
    chk("ctrl", dflt_ctrl(), framer_ctrl[0]);
    rd_chk(fidx(3'd0, `FPC_OFS), 8'h00, 2'b00);
    rd_chk(fidx(3'd0, `RESET_OFS_T1), 8'h00, 2'b00);
    chk("ctrl", exp_cfg(v[1]), framer_ctrl[1]);
    chk("j_mode", 1'b1, device_j_mode);
    axi_wr(`E1_SELECT_IDX, 8'h01, 2'b00);
    axi_wr(fidx(3'd5, `RESET_OFS_E1), 8'h01, 2'b00);
    settle();
    chk("ctrl", dflt_ctrl(), framer_ctrl[5]);
    chk("ctrl", exp_cfg(v[4]), framer_ctrl[4]);
    chk("e1_mode", 1'b1, device_e1_mode);
    pin_pulse(5'd9);
    chk("j_mode", 1'b1, device_j_mode);
    chk("ctrl", exp_cfg(v[2]), framer_ctrl[2]);
    pin_pulse(5'd10);
    for (int f = 0; f < FR; f++) begin
      chk("ctrl", dflt_ctrl(), framer_ctrl[f]);
    end
    chk("j_mode", 1'b0, device_j_mode);
    chk("e1_mode", 1'b0, device_e1_mode);
    rd_chk(`STANDARD_SELECT_IDX, 8'h00, 2'b00);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
